// ==== cfg_pkg.sv ====
// cfg_pkg.sv - constants and types of the control flag and fault gating block
// assumes: compiled ahead of every other file of the block
package cfg_pkg;
  // selects on the move-to/from-control-register port
  localparam logic [2:0] SEL_SYS_CTRL  = 3'h0;
  localparam logic [2:0] SEL_DIR_BASE  = 3'h3;
  localparam logic [2:0] SEL_EXT_FLAGS = 3'h4;

  // system control register fields
  localparam int BIT_PROT_ON    = 0;
  localparam int BIT_WAIT_MON   = 1;
  localparam int BIT_FPU_ABSENT = 2;
  localparam int BIT_TASK_SW    = 3;
  localparam int BIT_COPROC     = 4;
  localparam int BIT_NATIVE_ERR = 5;
  localparam int BIT_CACHE_OFF  = 30;
  localparam int BIT_PAGING_ON  = 31;
  // page directory base register fields
  localparam int BIT_DIR_WT     = 3;
  localparam int BIT_DIR_CD     = 4;
  // extension flags register fields
  localparam int BIT_V86_EXT    = 0;
  localparam int BIT_PROT_VIRQ  = 1;
  localparam int BIT_CNT_RESTR  = 2;

  // bits that software may change, and values after reset
  localparam logic [31:0] SYS_CTRL_WR_MASK  = 32'he0050027;
  localparam logic [31:0] DIR_BASE_WR_MASK  = 32'hfffff018;
  localparam logic [31:0] EXT_FLAGS_WR_MASK = 32'h00000007;
  localparam logic [31:0] SYS_CTRL_RST      = 32'h00000000;
  localparam logic [31:0] DIR_BASE_RST      = 32'h00000000;
  localparam logic [31:0] EXT_FLAGS_RST     = 32'h00000000;
  localparam logic        TASK_SW_RST       = 1'h0;
  localparam logic [1:0]  CPL_KERNEL        = 2'h0;

  // instruction classes seen by the gating logic
  typedef enum logic [2:0] {
    CLS_NONE       = 3'h0,
    CLS_FP_ARITH   = 3'h1,
    CLS_FP_WAIT    = 3'h2,
    CLS_PACKED     = 3'h3,
    CLS_VECTOR     = 3'h4,
    CLS_VEC_EXEMPT = 3'h5,
    CLS_READ_CNT   = 3'h6
  } cfg_class_type;

  // floating-point error report states
  typedef enum logic [1:0] {
    ERR_IDLE = 2'h0,
    ERR_PEND = 2'h1,
    ERR_HALT = 2'h3
  } cfg_err_state_type;
endpackage : cfg_pkg

// ==== cfg_flags_if.sv ====
// cfg_flags_if.sv - live control flags passed from the register owner
// assumes: one owner drives the flags, the gating leaves only read them
`timescale 1ns/1ps
interface cfg_flags_if;
  logic wait_monitor_flag;
  logic fpu_absent_flag;
  logic task_switched_flag;
  logic native_error_report;
  modport owner (output wait_monitor_flag, fpu_absent_flag,
                 task_switched_flag, native_error_report);
  modport user  (input wait_monitor_flag, fpu_absent_flag,
                 task_switched_flag, native_error_report);
endinterface : cfg_flags_if

// ==== cfg_gate.sv ====
// cfg_gate.sv - decides unit-unavailable and invalid-opcode faults per instruction
// assumes: flags are registered by the owner, class is valid with i_valid
`timescale 1ns/1ps
module cfg_gate
  import cfg_pkg::*;
(
  cfg_flags_if.user          flags,
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst_n,
  input  wire logic          i_valid,
  input  wire cfg_class_type i_class,
  output logic               o_unit_unavailable_fault,
  output logic               o_invalid_opcode_fault
);
  logic fp_arith;
  logic fp_wait;
  logic simd;

  // instruction class decode
  assign fp_arith = (i_class == CLS_FP_ARITH);
  assign fp_wait  = (i_class == CLS_FP_WAIT);
  assign simd     = (i_class == CLS_PACKED) || (i_class == CLS_VECTOR);

  // invalid opcode first, then unit unavailable
  always_comb begin
    o_invalid_opcode_fault   = i_valid && simd && flags.fpu_absent_flag;
    o_unit_unavailable_fault = 1'b0;
    if (i_valid && !o_invalid_opcode_fault) begin
      if (fp_arith) begin
        o_unit_unavailable_fault = flags.fpu_absent_flag || flags.task_switched_flag;
      end else if (fp_wait) begin
        o_unit_unavailable_fault = flags.wait_monitor_flag && flags.task_switched_flag;
      end else if (simd) begin
        o_unit_unavailable_fault = flags.task_switched_flag;
      end
    end
  end

  a_emu_arith_nm: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_valid && fp_arith && flags.fpu_absent_flag) |-> o_unit_unavailable_fault)
    else $error("arith op ran with fpu absent");
  a_wait_gating: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_valid && fp_wait) |->
      (o_unit_unavailable_fault == (flags.wait_monitor_flag && flags.task_switched_flag)))
    else $error("wait gating wrong");
  a_switch_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_valid && (fp_arith || simd) && flags.task_switched_flag && !flags.fpu_absent_flag)
      |-> o_unit_unavailable_fault)
    else $error("switched task ran fp op");
  a_emu_simd_ud: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_valid && simd && flags.fpu_absent_flag) |->
      (o_invalid_opcode_fault && !o_unit_unavailable_fault))
    else $error("simd op not invalid with fpu absent");
  a_exempt_free: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_valid && (i_class == CLS_VEC_EXEMPT)) |->
      !(o_invalid_opcode_fault || o_unit_unavailable_fault))
    else $error("exempt op faulted");
  a_clean_flags: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!flags.task_switched_flag && !flags.fpu_absent_flag) |-> !o_unit_unavailable_fault)
    else $error("fault without switched or absent flag");
endmodule : cfg_gate

// ==== cfg_fpu_err.sv ====
// cfg_fpu_err.sv - floating-point error reporting, native or external pin
// assumes: error event and clear are one-cycle pulses from the fp unit
`timescale 1ns/1ps
module cfg_fpu_err
  import cfg_pkg::*;
(
  cfg_flags_if.user   flags,
  input  wire logic   i_clk_sys,
  input  wire logic   i_rst_n,
  input  wire logic   i_err_event,
  input  wire logic   i_err_clear,
  input  wire logic   i_waiting_instr,
  input  wire logic   i_ignore_fpu_error_in_n,
  output logic        o_fpu_error_out_n,
  output logic        o_native_fault,
  output logic        o_halt
);
  cfg_err_state_type state;
  cfg_err_state_type next_state;
  logic              ignore_err;
  logic              legacy;

  // legacy scheme, and the ignore input that mutes it
  assign legacy     = !flags.native_error_report;
  assign ignore_err = legacy && !i_ignore_fpu_error_in_n;

  // report state; a new event beats a clear
  always_comb begin
    next_state = state;
    unique case (state)
      ERR_IDLE: if (i_err_event && !ignore_err) next_state = ERR_PEND;
      ERR_PEND: begin
        if (i_err_clear && !i_err_event) next_state = ERR_IDLE;
        else if (i_waiting_instr && legacy && !ignore_err) next_state = ERR_HALT;
      end
      ERR_HALT: if (i_err_clear) next_state = i_err_event ? ERR_PEND : ERR_IDLE;
      default:  next_state = ERR_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) state <= ERR_IDLE;
    else state <= next_state;
  end

  // error pin, asserted low while a legacy error stands
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) o_fpu_error_out_n <= 1'b1;
    else o_fpu_error_out_n <= !((next_state != ERR_IDLE) && legacy && !ignore_err);
  end

  // native fault or halt at the next waiting instruction
  assign o_native_fault = (state == ERR_PEND) && i_waiting_instr && !legacy;
  assign o_halt = (state == ERR_HALT) ||
                  ((state == ERR_PEND) && i_waiting_instr && legacy && !ignore_err);

  a_ignore_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $past(ignore_err) |-> (o_fpu_error_out_n && !o_native_fault))
    else $error("ignored error was reported");
  a_legacy_raise: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_err_event && legacy && !ignore_err) |=> !o_fpu_error_out_n)
    else $error("error pin not raised");
  a_legacy_halt: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state == ERR_PEND && i_waiting_instr && legacy && !ignore_err)
      |-> o_halt ##1 (o_halt || $past(i_err_clear)))
    else $error("no halt at waiting instruction");
  a_native_path: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state == ERR_PEND && i_waiting_instr && !legacy) |-> (o_native_fault && !o_halt))
    else $error("native error not faulted");
  a_native_no_pin: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $past(!legacy) |-> o_fpu_error_out_n)
    else $error("pin used in native mode");
endmodule : cfg_fpu_err

// ==== cfg_control_flags.sv ====
// cfg_control_flags.sv - system control flags, their registers and fault gating
// assumes: one core clock; register moves, task switch and clear-switch
// arrive as one-cycle pulses from the decoder; faults answer in the same cycle
//
// Summary of operation
// - native flag set: fp errors fault internally; clear: external error pin.
// - native flag clear and ignore input low: fp errors are ignored.
// - legacy, not ignored: error pin asserts, halt at next waiting fp op.
// - coprocessor type bit reads one always and ignores writes.
// - task switch sets the switched flag; fp, packed, vector ops test it.
// - switched flag set, fpu absent clear: unit fault before fp arithmetic, packed, vector ops.
// - wait faults only when monitor and switched flags are both set.
// - fpu absent set: every fp arithmetic op takes a unit fault.
// - fpu absent set: packed integer ops take an invalid opcode fault.
// - fpu absent set: vector ops invalid, except the exempt group.
// - task switch saves no context; it only sets the switched flag.
// - clear-switch instruction zeroes only the switched flag.
// - protection flag picks protected mode; paging needs protection and paging.
// - directory no-cache honoured only with paging on and cache enabled.
// - directory write-through honoured only with paging on and cache enabled.
// - v86 extensions enable redirection and virtual irq flag in v86 mode.
// - protected virtual irq flag enables virtual irq support in protected mode.
// - counter restrict set: cycle counter read only at privilege zero.
// - writing paging on with protection off raises general protection.
`timescale 1ns/1ps
module cfg_control_flags
  import cfg_pkg::*;
(
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst_n,
  // control register moves
  input  wire logic          i_reg_wr,
  input  wire logic          i_reg_rd,
  input  wire logic [2:0]    i_reg_sel,
  input  wire logic [31:0]   i_reg_wdata,
  output logic [31:0]        o_reg_rdata,
  output logic               o_reg_rvalid,
  // privilege and task events
  input  wire logic [1:0]    i_cpl,
  input  wire logic          i_v86_mode,
  input  wire logic          i_task_switch,
  input  wire logic          i_clear_switch_flag_instr,
  // instruction gating
  input  wire logic          i_instr_valid,
  input  wire cfg_class_type i_instr_class,
  output logic               o_exec_ok,
  output logic               o_unit_unavailable_fault,
  output logic               o_invalid_opcode_fault,
  output logic               o_general_protection_fault,
  output logic               o_native_fpu_fault,
  output logic               o_halt_exec,
  // floating-point error reporting
  input  wire logic          i_fpu_error_event,
  input  wire logic          i_fpu_error_clear,
  input  wire logic          i_ignore_fpu_error_in_n,
  output logic               o_fpu_error_out_n,
  // mode levels for the rest of the core
  output logic               o_protected_mode,
  output logic               o_paging_active,
  output logic               o_dir_no_cache,
  output logic               o_dir_write_thru,
  output logic               o_v86_redirect,
  output logic               o_virtual_irq_en,
  output logic               o_counter_read_ok
);
  logic [31:0] sys_flags;
  logic        task_sw;
  logic [31:0] dir_base;
  logic [31:0] ext_flags;
  logic [31:0] ctrl_word;
  logic        priv_ok;
  logic        ctrl_wr;
  logic        wr_bad;
  logic        wr_ok;
  logic        clear_switch_flag_instr_ok;
  logic        clear_switch_flag_instr_bad;
  logic        rd_bad;
  logic        cnt_bad;
  logic        waiting;
  logic        cache_on;

  cfg_flags_if flags_bus ();

  // privilege: real mode or level zero may touch control state
  assign priv_ok = !sys_flags[BIT_PROT_ON] || (i_cpl == CPL_KERNEL);

  // write, clear and read checks
  // a refused move is dropped whole; the fault is the only trace it leaves
  assign ctrl_wr  = i_reg_wr && (i_reg_sel == SEL_SYS_CTRL);
  assign wr_bad   = i_reg_wr && (!priv_ok ||
                    (ctrl_wr && i_reg_wdata[BIT_PAGING_ON] &&
                     !i_reg_wdata[BIT_PROT_ON]));
  assign wr_ok    = i_reg_wr && !wr_bad;
  assign clear_switch_flag_instr_bad = i_clear_switch_flag_instr && !priv_ok;
  assign clear_switch_flag_instr_ok  = i_clear_switch_flag_instr && priv_ok;
  assign rd_bad   = i_reg_rd && !priv_ok;

  // cycle counter read permission
  // the restrict flag only narrows who may read; level zero is never refused
  assign o_counter_read_ok = !ext_flags[BIT_CNT_RESTR] || (i_cpl == CPL_KERNEL);
  assign cnt_bad = i_instr_valid && (i_instr_class == CLS_READ_CNT) && !o_counter_read_ok;

  // general protection from any refused access
  assign o_general_protection_fault = wr_bad || clear_switch_flag_instr_bad || rd_bad || cnt_bad;

  // system control bits other than the switched flag
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sys_flags <= SYS_CTRL_RST;
    end else if (wr_ok && ctrl_wr) begin
      sys_flags <= i_reg_wdata & SYS_CTRL_WR_MASK;
    end
  end

  // switched flag: task switch wins over clear and write
  // a switch and a clear in one cycle leave it set, so the new task still faults
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      task_sw <= TASK_SW_RST;
    end else if (i_task_switch) begin
      task_sw <= 1'b1;
    end else if (clear_switch_flag_instr_ok) begin
      task_sw <= 1'b0;
    end else if (wr_ok && ctrl_wr) begin
      task_sw <= i_reg_wdata[BIT_TASK_SW];
    end
  end

  // page directory base and extension flags
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_base  <= DIR_BASE_RST;
      ext_flags <= EXT_FLAGS_RST;
    end else if (wr_ok) begin
      // refused writes never get here, so a fault leaves both registers alone
      if (i_reg_sel == SEL_DIR_BASE) begin
        dir_base <= i_reg_wdata & DIR_BASE_WR_MASK;
      end
      if (i_reg_sel == SEL_EXT_FLAGS) begin
        ext_flags <= i_reg_wdata & EXT_FLAGS_WR_MASK;
      end
    end
  end

  // read view of the control word, type bit tied high
  always_comb begin
    ctrl_word              = sys_flags;
    ctrl_word[BIT_TASK_SW] = task_sw;
    ctrl_word[BIT_COPROC]  = 1'b1;
  end

  // read data, one cycle after the request; unmapped selects read zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata  <= 32'h00000000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd && !rd_bad;
      if (i_reg_rd && !rd_bad) begin
        unique case (i_reg_sel)
          SEL_SYS_CTRL:  o_reg_rdata <= ctrl_word;
          SEL_DIR_BASE:  o_reg_rdata <= dir_base;
          SEL_EXT_FLAGS: o_reg_rdata <= ext_flags;
          default:       o_reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // flags handed to the gating leaves
  assign flags_bus.wait_monitor_flag   = sys_flags[BIT_WAIT_MON];
  assign flags_bus.fpu_absent_flag     = sys_flags[BIT_FPU_ABSENT];
  assign flags_bus.task_switched_flag  = task_sw;
  assign flags_bus.native_error_report = sys_flags[BIT_NATIVE_ERR];

  // per-instruction fault decision
  cfg_gate u_gate (
    .flags                    (flags_bus),
    .i_clk_sys                (i_clk_sys),
    .i_rst_n                  (i_rst_n),
    .i_valid                  (i_instr_valid),
    .i_class                  (i_instr_class),
    .o_unit_unavailable_fault (o_unit_unavailable_fault),
    .o_invalid_opcode_fault   (o_invalid_opcode_fault)
  );

  // waiting fp ops that passed gating check for pending errors
  // gated ops never reach the error check, so the gating fault is taken first
  assign waiting = i_instr_valid && !o_unit_unavailable_fault && !o_invalid_opcode_fault &&
                   ((i_instr_class == CLS_FP_ARITH) || (i_instr_class == CLS_FP_WAIT));

  cfg_fpu_err u_fpu_err (
    .flags                   (flags_bus),
    .i_clk_sys               (i_clk_sys),
    .i_rst_n                 (i_rst_n),
    .i_err_event             (i_fpu_error_event),
    .i_err_clear             (i_fpu_error_clear),
    .i_waiting_instr         (waiting),
    .i_ignore_fpu_error_in_n (i_ignore_fpu_error_in_n),
    .o_fpu_error_out_n       (o_fpu_error_out_n),
    .o_native_fault          (o_native_fpu_fault),
    .o_halt                  (o_halt_exec)
  );

  // instruction may retire only with no fault and no halt
  assign o_exec_ok = i_instr_valid && !o_unit_unavailable_fault &&
                     !o_invalid_opcode_fault && !cnt_bad &&
                     !o_native_fpu_fault && !o_halt_exec;

  // operating mode and directory cache attributes
  assign cache_on         = !sys_flags[BIT_CACHE_OFF];
  assign o_protected_mode = sys_flags[BIT_PROT_ON];
  assign o_paging_active  = sys_flags[BIT_PROT_ON] && sys_flags[BIT_PAGING_ON];
  assign o_dir_no_cache   = o_paging_active && cache_on && dir_base[BIT_DIR_CD];
  assign o_dir_write_thru = o_paging_active && cache_on && dir_base[BIT_DIR_WT];

  // virtual interrupt support
  assign o_v86_redirect   = ext_flags[BIT_V86_EXT] && i_v86_mode;
  assign o_virtual_irq_en = o_v86_redirect ||
                            (ext_flags[BIT_PROT_VIRQ] && sys_flags[BIT_PROT_ON] &&
                             !i_v86_mode);

  // register port and flag checks
  a_coproc_fixed: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (o_reg_rvalid && $past(i_reg_sel) == SEL_SYS_CTRL) |-> o_reg_rdata[BIT_COPROC])
    else $error("coprocessor type bit read as zero");
  a_switch_sets: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_task_switch |=> task_sw)
    else $error("task switch left flag clear");
  a_switch_only: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_task_switch && !wr_ok) |=> $stable(sys_flags))
    else $error("task switch changed other flags");
  a_clear_only: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (clear_switch_flag_instr_ok && !i_task_switch && !wr_ok) |=> (!task_sw && $stable(sys_flags)))
    else $error("clear-switch misbehaved");
  a_paging_pair: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_paging_active |-> (o_protected_mode && sys_flags[BIT_PAGING_ON]))
    else $error("paging without protection");
  a_paging_gp: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (ctrl_wr && i_reg_wdata[BIT_PAGING_ON] && !i_reg_wdata[BIT_PROT_ON])
      |-> o_general_protection_fault ##1 $stable(sys_flags))
    else $error("paging write without protection accepted");
  a_dir_ignored: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!o_paging_active || sys_flags[BIT_CACHE_OFF]) |-> !(o_dir_no_cache || o_dir_write_thru))
    else $error("directory attribute honoured while ignored");
  a_counter_priv: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_instr_valid && i_instr_class == CLS_READ_CNT) |->
      (o_general_protection_fault ==
       (ext_flags[BIT_CNT_RESTR] && i_cpl != CPL_KERNEL)))
    else $error("cycle counter permission wrong");
  a_write_next: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (wr_ok && ctrl_wr) ##1 (i_instr_valid && i_instr_class == CLS_PACKED)
      |-> (o_invalid_opcode_fault == $past(i_reg_wdata[BIT_FPU_ABSENT])))
    else $error("written flag not in force next instruction");
  a_v86_redirect: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (ext_flags[BIT_V86_EXT] && i_v86_mode) |-> (o_v86_redirect && o_virtual_irq_en))
    else $error("v86 extensions not applied");
  a_pvi_enable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (o_protected_mode && !i_v86_mode) |-> (o_virtual_irq_en == ext_flags[BIT_PROT_VIRQ]))
    else $error("protected virtual irq wrong");

  // gating outcome, directory attribute and cycle counter checks
  a_exec_blocked: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (o_unit_unavailable_fault || o_invalid_opcode_fault || o_halt_exec) |-> !o_exec_ok)
    else $error("faulted instruction allowed to run");
  a_dir_attr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (o_paging_active && !sys_flags[BIT_CACHE_OFF]) |->
      ((o_dir_no_cache == dir_base[BIT_DIR_CD]) && (o_dir_write_thru == dir_base[BIT_DIR_WT])))
    else $error("directory attribute not applied");
  a_counter_free: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !ext_flags[BIT_CNT_RESTR] |-> o_counter_read_ok)
    else $error("cycle counter refused while unrestricted");

  // main scenarios
  c_unit_fault: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_task_switch ##1 (i_instr_valid && o_unit_unavailable_fault));
  c_invalid_op: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_invalid_opcode_fault);
  c_legacy_halt: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !o_fpu_error_out_n ##[1:8] o_halt_exec);
  c_clear_resume: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    clear_switch_flag_instr_ok ##1 (i_instr_valid && o_exec_ok));
  c_native_report: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_native_fpu_fault);
endmodule : cfg_control_flags

// ==== cfg_irq_glue.sv ====
// cfg_irq_glue.sv - error pin glue and interrupt controller request
// assumes: bench asks for the ignore pin; error pin is active low
`timescale 1ns/1ps
module cfg_irq_glue (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_fpu_error_out_n,
  input  wire logic i_ignore_req,
  output logic      o_ignore_fpu_error_in_n,
  output logic      o_irq_req
);
  // ignore pin pulled low on request
  assign o_ignore_fpu_error_in_n = !i_ignore_req;
  // error pin latched into the controller request line
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) o_irq_req <= 1'h0;
    else o_irq_req <= !i_fpu_error_out_n;
  end
endmodule : cfg_irq_glue

// ==== cfg_control_flags_bench.sv ====
// cfg_control_flags_bench.sv - self-checking bench of the control flag block
// assumes: cfg_pkg, the design files and cfg_irq_glue are compiled first
`timescale 1ns/1ps
module cfg_control_flags_bench;
  import cfg_pkg::*;
  logic i_clk_sys = 0, i_rst_n = 0, i_reg_wr = 0, i_reg_rd = 0, i_v86_mode = 0;
  logic i_task_switch = 0, i_clear_switch_flag_instr = 0, i_instr_valid = 0;
  logic i_fpu_error_event = 0, i_fpu_error_clear = 0, ign = 0, irq, i_ignore_fpu_error_in_n;
  logic [2:0] i_reg_sel = 0, f, c;
  logic [31:0] i_reg_wdata = 0, o_reg_rdata;
  logic [1:0] i_cpl = 0;
  cfg_class_type i_instr_class = CLS_NONE;
  logic o_reg_rvalid, o_exec_ok, o_unit_unavailable_fault, o_invalid_opcode_fault;
  logic o_general_protection_fault, o_native_fpu_fault, o_halt_exec, o_fpu_error_out_n;
  logic o_protected_mode, o_paging_active, o_dir_no_cache, o_dir_write_thru;
  logic o_v86_redirect, o_virtual_irq_en, o_counter_read_ok;
  int n_errors = 0, checks_done = 0, cycles = 0, seed = 32'h3d13f037;
  // core clock, 25 ns
  always #12.5 i_clk_sys = ~i_clk_sys;
  cfg_control_flags DUT (.*);
  cfg_irq_glue glue (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_fpu_error_out_n(o_fpu_error_out_n),
    .i_ignore_req(ign), .o_ignore_fpu_error_in_n(i_ignore_fpu_error_in_n), .o_irq_req(irq));
  task automatic chk(string s, logic [32:0] seen, logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // register move, protection fault looked at in the request cycle
  task automatic wr(logic [2:0] s, logic [31:0] d, logic gp);
    @(negedge i_clk_sys) {i_instr_valid, i_reg_wr, i_reg_sel, i_reg_wdata} = {2'h1, s, d};
    #1 chk("gp", o_general_protection_fault, gp);
    @(negedge i_clk_sys) i_reg_wr = 1'h0;
  endtask : wr
  task automatic rd(logic [2:0] s, logic [31:0] e);
    @(negedge i_clk_sys) {i_reg_rd, i_reg_sel} = {1'h1, s};
    @(negedge i_clk_sys) i_reg_rd = 1'h0;
    chk("rdata", {o_reg_rvalid, o_reg_rdata}, {1'h1, e});
  endtask : rd
  // op starts on the falling edge the caller stands on, so it meets a write's next edge
  task automatic op(logic [2:0] k, logic [1:0] e);
    i_instr_valid = 1'h1;
    i_instr_class = cfg_class_type'(k);
    #1 chk("fault", {o_invalid_opcode_fault, o_unit_unavailable_fault}, e);
    @(negedge i_clk_sys);
  endtask : op
  task automatic pulse(ref logic p);
    @(negedge i_clk_sys) p = 1'h1;
    @(negedge i_clk_sys) p = 1'h0;
  endtask : pulse
  // expected {invalid, unit} faults; f holds switched, absent, monitor
  function automatic logic [1:0] want(logic [2:0] g, logic [2:0] k);
    logic ud;
    ud = g[1] && (k == 3'h3 || k == 3'h4);
    return {ud, !ud && ((k == 3'h1 && g[2:1] != 0) || (k == 3'h2 && g[2] && g[0])
            || ((k == 3'h3 || k == 3'h4) && g[2]))};
  endfunction : want
  // hang guard
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    repeat (16) @(posedge i_clk_sys);
    @(negedge i_clk_sys) i_rst_n = 1'h1;
    rd(3'h0, 32'h10);
    wr(3'h0, 32'hffffffef, 1'h0);
    rd(3'h0, 32'he005003f);
    chk("mode", {o_protected_mode, o_paging_active}, 2'h3);
    wr(3'h3, 32'h18, 1'h0);
    chk("dir", {o_dir_no_cache, o_dir_write_thru}, 2'h0);
    wr(3'h0, 32'h80000001, 1'h0);
    chk("dir", {o_dir_no_cache, o_dir_write_thru}, 2'h3);
    wr(3'h0, 32'h80000000, 1'h1);
    rd(3'h0, 32'h80000011);
    wr(3'h0, 32'h0, 1'h0);
    wr(3'h4, 32'h7, 1'h0);
    i_cpl = 2'h3;
    i_v86_mode = 1'h1;
    #1 chk("cnt", {o_counter_read_ok, o_v86_redirect}, 2'h1);
    i_cpl = 2'h0;
    i_v86_mode = 1'h0;
    wr(3'h0, 32'h1, 1'h0);
    chk("virq", {o_virtual_irq_en, o_counter_read_ok}, 2'h3);
    i_cpl = 2'h3;
    op(3'h6, 2'h0);
    chk("cntgp", {o_general_protection_fault, o_exec_ok}, 2'h2);
    wr(3'h0, 32'h0, 1'h1);
    i_cpl = 2'h0;
    $display("end modes");
    pulse(i_task_switch);
    op(3'h3, 2'h1);
    op(3'h2, 2'h0);
    pulse(i_clear_switch_flag_instr);
    op(3'h3, 2'h0);
    rd(3'h0, 32'h11);
    wr(3'h0, 32'hc, 1'h0);
    op(3'h3, 2'h2);
    for (int i = 0; i < 40; i++) begin
      f = 3'($random(seed));
      c = 3'(($random(seed) & 32'hff) % 6) + 3'h1;
      wr(3'h0, {28'h0, f, 1'h0}, 1'h0);
      op(c, want(f, c));
      chk("exec", o_exec_ok, want(f, c) == 2'h0);
    end
    $display("end gating");
    wr(3'h0, 32'h0, 1'h0);
    pulse(i_fpu_error_event);
    repeat (2) @(negedge i_clk_sys);
    chk("pin", {o_fpu_error_out_n, irq}, 2'h1);
    op(3'h1, 2'h0);
    chk("halt", o_halt_exec, 1'h1);
    pulse(i_fpu_error_clear);
    repeat (2) @(negedge i_clk_sys);
    chk("free", {o_fpu_error_out_n, o_halt_exec}, 2'h2);
    ign = 1'h1;
    pulse(i_fpu_error_event);
    op(3'h1, 2'h0);
    chk("mute", {o_fpu_error_out_n, o_halt_exec, o_native_fpu_fault}, 3'h4);
    ign = 1'h0;
    pulse(i_fpu_error_clear);
    wr(3'h0, 32'h20, 1'h0);
    pulse(i_fpu_error_event);
    op(3'h1, 2'h0);
    chk("native", {o_native_fpu_fault, o_fpu_error_out_n}, 2'h3);
    pulse(i_fpu_error_clear);
    $display("end errors");
    tally_and_finish();
  end
endmodule : cfg_control_flags_bench
